// ===== verilog/cgs_clk_div.sv
package cgs_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned STRAP_TIME_US = 2000;
  localparam int unsigned STRAP_CYCLES = STRAP_TIME_US * CLK_MHZ;
  localparam int unsigned STRAP_CNT_W = 20;
  localparam int unsigned HALF_W = 5;
  // ==========================================================
  // Half periods in core clocks, scaled model of each rate
  localparam logic [4:0] HALF_HOST_133 = 5'h03;
  localparam logic [4:0] HALF_HOST_100 = 5'h04;
  localparam logic [4:0] HALF_HOST_66 = 5'h06;
  localparam logic [4:0] HALF_PERIPH = 5'h0C;
  localparam logic [4:0] HALF_LEGACY_24 = 5'h10;
  localparam logic [4:0] HALF_LEGACY_48 = 5'h08;
  localparam logic [4:0] HALF_REF = 5'h1C;
  // ==========================================================
  // Strap pin positions
  localparam int unsigned STRAP_PINS = 6;
  localparam int unsigned PIN_LEGACY = 5;
  localparam int unsigned PIN_REF = 3;
  localparam int unsigned PIN_FIXED48 = 4;
  // ==========================================================
  // Reset values and named codes
  localparam logic [4:0] FREQ_CODE_RST = 5'h00;
  localparam logic [4:0] CODE_FULL_66 = 5'h0C;
  localparam logic [4:0] CODE_FULL_100 = 5'h1D;
  localparam logic [4:0] CODE_FULL_133 = 5'h1E;
  localparam logic [1:0] LOW_EDGES_NEEDED = 2'h2;

  typedef enum logic [2:0] {
    CGS_ST_STRAP = 3'h1,
    CGS_ST_RUN = 3'h2,
    CGS_ST_DOWN = 3'h4
  } cgs_state_t;
endpackage

// Toggle divider; output held low and counter cleared while stopped
module cgs_clk_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [cgs_pkg::HALF_W-1:0] half,
  // Clock out
  output logic clk_o,
  output logic rise,
  output logic fall
);
  logic [cgs_pkg::HALF_W-1:0] cnt_r;
  logic hit;

  assign hit = run && (cnt_r + 5'h01 >= half);
  assign rise = hit && !clk_o;
  assign fall = hit && clk_o;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (!run || hit) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_o <= 1'b0;
    end else if (!run) begin
      clk_o <= 1'b0;
    end else if (hit) begin
      clk_o <= !clk_o;
    end
  end
endmodule // cgs_clk_div

// ===== verilog/cgs_clock_gen.sv
module cgs_clock_gen #(
  parameter int unsigned STRAP_CYCLES = cgs_pkg::STRAP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Power management
  input wire logic power_down_n,
  output logic pll_enable,
  output logic powered_down,
  // Dual-purpose strap pins: 0..4 select bits, 5 legacy-I/O select
  input wire logic [cgs_pkg::STRAP_PINS-1:0] strap_pin_in,
  output logic [cgs_pkg::STRAP_PINS-1:0] strap_pin_out,
  output logic [cgs_pkg::STRAP_PINS-1:0] strap_pin_oe,
  // Clock outputs
  output logic [1:0] host_clock_out,
  output logic [12:0] memory_clock_out,
  output logic [4:0] periph_clock_out,
  output logic intr_ctrl_clock_out,
  // Latched straps
  output logic [4:0] freq_select_code,
  output logic legacy_io_clock_sel
);
  // ==========================================================
  // Rate lookup
  function automatic logic [4:0] host_half_of(input logic [4:0] code);
    case (code)
      5'h0C, 5'h08, 5'h18, 5'h19, 5'h00, 5'h1C: host_half_of = cgs_pkg::HALF_HOST_66;
      5'h0E, 5'h0F, 5'h1E, 5'h1F, 5'h1B, 5'h1A, 5'h02, 5'h03, 5'h04, 5'h06,
      5'h07, 5'h0A, 5'h0B, 5'h10, 5'h11, 5'h12: host_half_of = cgs_pkg::HALF_HOST_133;
      default: host_half_of = cgs_pkg::HALF_HOST_100;
    endcase
  endfunction

  function automatic logic [4:0] mem_half_of(input logic [4:0] code);
    case (code)
      5'h02, 5'h04, 5'h06, 5'h0A, 5'h0E, 5'h14, 5'h1B, 5'h1E: mem_half_of = cgs_pkg::HALF_HOST_133;
      default: mem_half_of = cgs_pkg::HALF_HOST_100;
    endcase
  endfunction

  // ==========================================================
  // State
  cgs_pkg::cgs_state_t state_r;
  logic [cgs_pkg::STRAP_CNT_W-1:0] strap_cnt_r;
  logic pd_meta_r;
  logic pd_sync_r;
  logic [1:0] low_edges_r;
  logic [cgs_pkg::STRAP_PINS-1:0] strap_meta_r;
  logic [cgs_pkg::STRAP_PINS-1:0] strap_sync_r;
  logic [4:0] code_r;
  logic legacy_sel_r;
  logic running;
  logic strap_done;
  logic [4:0] host_half;
  logic [4:0] mem_half;
  logic [4:0] legacy_half;
  logic host_clk;
  logic host_rise;
  logic host_fall;
  logic mem_clk;
  logic periph_clk;
  logic legacy_clk;
  logic ref_clk;
  logic fixed48_clk;
  logic antiphase;
  logic mem_out;

  assign running = (state_r == cgs_pkg::CGS_ST_RUN);
  assign strap_done = (strap_cnt_r >= STRAP_CYCLES[cgs_pkg::STRAP_CNT_W-1:0] - 20'h00001);
  assign host_half = host_half_of(code_r);
  assign mem_half = mem_half_of(code_r);
  assign legacy_half = legacy_sel_r ? cgs_pkg::HALF_LEGACY_24 : cgs_pkg::HALF_LEGACY_48;
  assign antiphase = (host_half == cgs_pkg::HALF_HOST_100) && (mem_half == cgs_pkg::HALF_HOST_100);

  // ==========================================================
  // Synchronisers for the asynchronous inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_meta_r <= 1'b1;
      pd_sync_r <= 1'b1;
    end else begin
      pd_meta_r <= power_down_n;
      pd_sync_r <= pd_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta_r <= '0;
      strap_sync_r <= '0;
    end else begin
      strap_meta_r <= strap_pin_in;
      strap_sync_r <= strap_meta_r;
    end
  end

  // ==========================================================
  // Strap window counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_r <= '0;
    end else if (state_r == cgs_pkg::CGS_ST_STRAP && !strap_done) begin
      strap_cnt_r <= strap_cnt_r + 20'h00001;
    end
  end

  // Straps caught once; only a new reset reopens the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= cgs_pkg::FREQ_CODE_RST;
      legacy_sel_r <= 1'b0;
    end else if (state_r == cgs_pkg::CGS_ST_STRAP && strap_done) begin
      code_r <= strap_sync_r[4:0];
      legacy_sel_r <= strap_sync_r[cgs_pkg::PIN_LEGACY];
    end
  end

  // ==========================================================
  // Low-edge counter on host rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_edges_r <= 2'h0;
    end else if (pd_sync_r) begin
      low_edges_r <= 2'h0;
    end else if (host_rise && low_edges_r != cgs_pkg::LOW_EDGES_NEEDED) begin
      low_edges_r <= low_edges_r + 2'h1;
    end
  end

  // ==========================================================
  // Mode control; power-down is not honoured inside the strap window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cgs_pkg::CGS_ST_STRAP;
    end else begin
      case (state_r)
        cgs_pkg::CGS_ST_STRAP: begin
          if (strap_done) begin
            state_r <= cgs_pkg::CGS_ST_RUN;
          end
        end
        cgs_pkg::CGS_ST_RUN: begin
          if (low_edges_r == cgs_pkg::LOW_EDGES_NEEDED && host_fall && !pd_sync_r) begin
            state_r <= cgs_pkg::CGS_ST_DOWN;
          end
        end
        cgs_pkg::CGS_ST_DOWN: begin
          if (pd_sync_r) begin
            state_r <= cgs_pkg::CGS_ST_RUN;
          end
        end
        default: state_r <= cgs_pkg::CGS_ST_STRAP;
      endcase
    end
  end

  // ==========================================================
  // Clock groups; the host fall that triggers entry lands low and stays low
  cgs_clk_div u_host (.clk(clk), .rst_n(rst_n), .run(running), .half(host_half),
    .clk_o(host_clk), .rise(host_rise), .fall(host_fall));
  cgs_clk_div u_mem (.clk(clk), .rst_n(rst_n), .run(running), .half(mem_half),
    .clk_o(mem_clk), .rise(), .fall());
  cgs_clk_div u_periph (.clk(clk), .rst_n(rst_n), .run(running), .half(cgs_pkg::HALF_PERIPH),
    .clk_o(periph_clk), .rise(), .fall());
  cgs_clk_div u_legacy (.clk(clk), .rst_n(rst_n), .run(running), .half(legacy_half),
    .clk_o(legacy_clk), .rise(), .fall());
  cgs_clk_div u_ref (.clk(clk), .rst_n(rst_n), .run(running), .half(cgs_pkg::HALF_REF),
    .clk_o(ref_clk), .rise(), .fall());
  cgs_clk_div u_fixed48 (.clk(clk), .rst_n(rst_n), .run(running), .half(cgs_pkg::HALF_LEGACY_48),
    .clk_o(fixed48_clk), .rise(), .fall());

  // Antiphase reuses the host divider, so the two never drift apart
  assign mem_out = antiphase ? (running && !host_clk) : mem_clk;

  assign host_clock_out = {2{host_clk}};
  assign memory_clock_out = {13{mem_out}};
  assign periph_clock_out = {5{periph_clk}};
  assign intr_ctrl_clock_out = periph_clk;
  assign pll_enable = (state_r != cgs_pkg::CGS_ST_DOWN);
  assign powered_down = (state_r == cgs_pkg::CGS_ST_DOWN);
  assign freq_select_code = code_r;
  assign legacy_io_clock_sel = legacy_sel_r;

  // ==========================================================
  // Dual-purpose pins
  assign strap_pin_oe = (state_r == cgs_pkg::CGS_ST_STRAP) ? '0 : '1;
  assign strap_pin_out = {legacy_clk, fixed48_clk, ref_clk, {3{periph_clk}}};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pll_off_a: assert property (powered_down |-> !pll_enable && host_clock_out == 2'h0)
    else $error("pll or host clock active in power-down");
  outs_low_a: assert property ($rose(powered_down) |-> ##[0:4] memory_clock_out == 13'h0000
      && periph_clock_out == 5'h00 && !intr_ctrl_clock_out && strap_pin_out == 6'h00)
    else $error("clocks not low after power-down");
  enter_down_a: assert property ($rose(powered_down) |-> $past(low_edges_r) == 2'h2 && $past(host_fall))
    else $error("power-down entered without two low edges");
  sync_delay_a: assert property ($fell(pd_sync_r) |-> $past(power_down_n, 2) == 1'b0)
    else $error("power-down bypassed synchroniser");
  wake_up_a: assert property (powered_down && pd_sync_r |=> running)
    else $error("power-down held while input high");
  strap_in_a: assert property (state_r == cgs_pkg::CGS_ST_STRAP |-> strap_pin_oe == 6'h00)
    else $error("strap pin driven during sampling");
  strap_out_a: assert property ($rose(running) && $past(strap_pin_oe) == 6'h00 |-> strap_pin_oe == 6'h3F)
    else $error("strap pins not turned to outputs");
  code_hold_a: assert property ($past(state_r) != cgs_pkg::CGS_ST_STRAP |-> $stable(freq_select_code)
      && $stable(legacy_io_clock_sel))
    else $error("latched straps changed");
  code_catch_a: assert property ($past(state_r) == cgs_pkg::CGS_ST_STRAP && running
      |-> freq_select_code == $past(strap_sync_r[4:0]))
    else $error("code not taken from straps");
  rate_pick_a: assert property (running && freq_select_code == 5'h1D |-> host_half == 5'h04)
    else $error("100 MHz code gave wrong host rate");
  antiphase_a: assert property (running && antiphase |-> memory_clock_out[0] == !host_clock_out[0])
    else $error("memory clock not in antiphase");
  legacy_rate_a: assert property (legacy_io_clock_sel |-> legacy_half == 5'h10)
    else $error("legacy clock rate wrong");
  intr_sync_a: assert property (intr_ctrl_clock_out == periph_clock_out[0])
    else $error("interrupt clock not with peripheral clock");
endmodule // cgs_clock_gen

// ===== tb/cgs_board_model.sv
// ==========================================================
// Board straps and power-management request
module cgs_board_model (
  // Board side
  input wire logic [5:0] strap_level,
  input wire logic pd_req,
  // Device pins
  input wire logic [5:0] strap_pin_out,
  input wire logic [5:0] strap_pin_oe,
  output logic [5:0] strap_pin_in,
  output logic power_down_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device drive wins; otherwise the 10k resistor sets the level, never the weak pull
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      strap_pin_in[i] = strap_pin_oe[i] ? strap_pin_out[i] : strap_level[i];
    end
  end
  // Request is active high on the board side
  assign power_down_n = ~pd_req;
endmodule // cgs_board_model

// ===== tb/cgs_clock_gen_tb_top.sv
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
// ==========================================================
// Top of the bench
module cgs_clock_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short strap window keeps the run brief
  localparam int unsigned SC = 20;
  logic clk, rst_n, pd_req, power_down_n, pll_enable, powered_down, intr, legacy;
  logic [5:0] strap_level, strap_pin_in, strap_pin_out, strap_pin_oe;
  logic [1:0] host;
  logic [12:0] mem;
  logic [4:0] periph, code;
  int mismatches, total_checks, cycles;
  int seed = 32'h8587;
  // Watched clocks: host, periph, legacy, memory, reference, fixed 48, interrupt
  wire [6:0] watch = {intr, strap_pin_out[4:3], mem[0], strap_pin_out[5], periph[0], host[0]};

  cgs_clock_gen #(.STRAP_CYCLES(SC)) DUT (.clk(clk), .rst_n(rst_n), .power_down_n(power_down_n),
    .pll_enable(pll_enable), .powered_down(powered_down), .strap_pin_in(strap_pin_in),
    .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe), .host_clock_out(host),
    .memory_clock_out(mem), .periph_clock_out(periph), .intr_ctrl_clock_out(intr),
    .freq_select_code(code), .legacy_io_clock_sel(legacy));
  cgs_board_model board (.strap_level(strap_level), .pd_req(pd_req), .strap_pin_out(strap_pin_out),
    .strap_pin_oe(strap_pin_oe), .strap_pin_in(strap_pin_in), .power_down_n(power_down_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Expectations
  function automatic logic [4:0] exp_host_half(input logic [4:0] c);
    case (c)
      5'h00, 5'h08, 5'h0C, 5'h18, 5'h19, 5'h1C: return cgs_pkg::HALF_HOST_66;
      5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h1A, 5'h1B,
        5'h1E, 5'h1F: return cgs_pkg::HALF_HOST_133;
      default: return cgs_pkg::HALF_HOST_100;
    endcase
  endfunction
  function automatic bit mem_fast(input logic [4:0] c);
    return c inside {5'h02, 5'h04, 5'h06, 5'h0A, 5'h0E, 5'h14, 5'h1B, 5'h1E};
  endfunction
  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // High time in core cycles of one watched clock, bounded waits
  // First phase after start may be short, so it is never timed
  task automatic measure(input int which, output int half);
    int n;
    n = 0;
    while (watch[which] !== 1'b0 && n < 200) begin @(negedge clk); n++; end
    n = 0;
    while (watch[which] !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    half = 0;
    while (watch[which] === 1'b1 && half < 200) begin @(negedge clk); half++; end
  endtask
  task automatic run_case(input logic [5:0] s, input int idx);
    int m;
    @(posedge clk);
    strap_level <= s;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK(strap_pin_oe, 6'h00)
    repeat (SC + 2) @(negedge clk);
    `CHK(strap_pin_oe, 6'h3F)
    `CHK(code, s[4:0])
    `CHK(legacy, s[5])
    @(posedge clk);
    strap_level <= ~s;
    measure(0, m);
    `CHK(m, int'(exp_host_half(s[4:0])))
    measure(2, m);
    `CHK(m, int'(s[5] ? cgs_pkg::HALF_LEGACY_24 : cgs_pkg::HALF_LEGACY_48))
    measure(3, m);
    `CHK(m, int'(mem_fast(s[4:0]) ? cgs_pkg::HALF_HOST_133 : cgs_pkg::HALF_HOST_100))
    measure(4, m);
    `CHK(m, int'(cgs_pkg::HALF_REF))
    measure(5, m);
    `CHK(m, int'(cgs_pkg::HALF_LEGACY_48))
    measure(1, m);
    `CHK(m, int'(cgs_pkg::HALF_PERIPH))
    `CHK(strap_pin_out[2:0], {3{periph[0]}})
    measure(6, m);
    `CHK(m, int'(cgs_pkg::HALF_PERIPH))
    `CHK(intr, periph[0])
    if (exp_host_half(s[4:0]) == cgs_pkg::HALF_HOST_100 && !mem_fast(s[4:0])) begin
      repeat (8) begin @(negedge clk); `CHK(mem, {13{~host[0]}}) end
    end
    `CHK(code, s[4:0])
    $display("test %0d done", idx);
  endtask
  task automatic power_cycle(input int h);
    int n;
    @(posedge clk);
    pd_req <= 1'b1;
    n = 0;
    while (powered_down !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    `CHK(powered_down, 1'b1)
    `CHK(n >= 2 * h, 1'b1)
    repeat (2) @(negedge clk);
    `CHK(pll_enable, 1'b0)
    `CHK({host, mem, periph, intr, strap_pin_out}, 27'h0000000)
    @(posedge clk);
    pd_req <= 1'b0;
    n = 0;
    while (powered_down !== 1'b0 && n < 20) begin @(negedge clk); n++; end
    `CHK(n <= 4, 1'b1)
    `CHK(pll_enable, 1'b1)
    // One-cycle glitch must be filtered
    @(posedge clk);
    pd_req <= 1'b1;
    @(posedge clk);
    pd_req <= 1'b0;
    repeat (30) @(negedge clk);
    `CHK(powered_down, 1'b0)
    $display("power-down test done");
  endtask
  // ==========================================================
  // Main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin mismatches++; summarize(); end
  end
  initial begin
    logic [5:0] s;
    rst_n = 1'b0;
    pd_req = 1'b0;
    strap_level = 6'h00;
    for (int i = 0; i < 9; i++) begin
      s = 6'($random(seed));
      if (i == 0) s[4:0] = cgs_pkg::CODE_FULL_66;
      if (i == 1) s[4:0] = cgs_pkg::CODE_FULL_100;
      if (i == 2) s[4:0] = cgs_pkg::CODE_FULL_133;
      run_case(s, i);
      if (i == 1) power_cycle(int'(cgs_pkg::HALF_HOST_100));
    end
    summarize();
  end
endmodule // cgs_clock_gen_tb_top
